// ==== core/fpsrc_pkg.sv ====
// Package with shared constants and types for the flash power and reset control link
package fpsrc_pkg;
	// Clock period in picoseconds
	localparam int CLK_PS = 5000;
	// Documented times in their own units
	localparam int WAKE_DELAY_NS = 30000;
	localparam int ENTRY_DELAY_NS = 3000;
	localparam int SEL_DELAY_US = 30;
	localparam int PUW_DELAY_MS = 1;
	localparam int RECOVERY_DELAY_NS = 30000;
	localparam int STATUS_WRITE_US = 15;
	// Derived cycle counts, least times rounded up
	localparam int WAKE_CYC = (WAKE_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int ENTRY_CYC = (ENTRY_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int SEL_CYC = (SEL_DELAY_US * 1000000 + CLK_PS - 1) / CLK_PS;
	localparam int PUW_CYC = (PUW_DELAY_MS * 1000 + CLK_PS / 1000 - 1) / (CLK_PS / 1000) * 1000;
	localparam int RECOVERY_CYC = (RECOVERY_DELAY_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam int STATUS_WRITE_CYC = (STATUS_WRITE_US * 1000000 + CLK_PS - 1) / CLK_PS;
	// Command codes
	localparam logic [7:0] CMD_WREN = 8'h06;
	localparam logic [7:0] CMD_WRDI = 8'h04;
	localparam logic [7:0] CMD_READ = 8'h03;
	localparam logic [7:0] CMD_PW = 8'h0A;
	localparam logic [7:0] CMD_PP = 8'h02;
	localparam logic [7:0] CMD_PE = 8'hDB;
	localparam logic [7:0] CMD_SE = 8'hD8;
	localparam logic [7:0] CMD_WRSR = 8'h01;
	localparam logic [7:0] CMD_DPD = 8'hB9;
	localparam logic [7:0] CMD_RDP = 8'hAB;
	// Host register offsets
	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	localparam logic [3:0] REG_CTRL = 4'h8;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	// Bit positions in host status
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_PWRUP = 2;
	localparam int ST_REC = 3;
	// Serial clock divider half period in aclk cycles
	localparam int SCK_HALF = 6;
	// Device power states
	typedef enum logic [2:0] {
		FPSRC_OFF = 3'b000,
		FPSRC_STBY = 3'b001,
		FPSRC_ENTER = 3'b010,
		FPSRC_DEEP = 3'b011,
		FPSRC_WAKE = 3'b100
	} fpsrc_pwr_e;
endpackage

// ==== core/fpsrc_if.sv ====
// Interface joining the flash power control device and its host
`timescale 1ns/100ps
interface fpsrc_if;
	logic sel_n;
	logic sck;
	logic serial_in_line;
	logic hw_reset_n;
	modport device (input sel_n, input sck, input serial_in_line, input hw_reset_n);
	modport host (output sel_n, output sck, output serial_in_line, output hw_reset_n);
endinterface

// ==== core/fpsrc_device.sv ====
// Device end: power state, power-up delays, reset pin handling and release command
//
// Summary of operation
// - Deep power-down ignores all but release
// - Host frames release with select low
// - Extra clocks reject the release command
// - Standby after wake delay; host waits
// - Release rejected during busy cycle
// - Host deselected until select delay
// - Supply low holds logic in reset
// - Write commands ignored until write delay
// - Reads accepted after select delay
// - Testbench sends one early write that is ignored, then sends writes after both delays
// - Power-up gives standby, cleared flags
// - Reset pin aborts cycle, clears locks
// - Reset while decoding restores power-on
// - Reset during program restores power-on
// - Reset during status write finishes it
// - Delivered status bits are zero
// - Supply loss stops all responses
// - Host may hold reset during power
// - Host waits recovery after reset
// - Deep power-down after entry delay
`timescale 1ns/100ps
module fpsrc_device import fpsrc_pkg::*; #(
	parameter int WAKE_N = WAKE_CYC,
	parameter int ENTRY_N = ENTRY_CYC,
	parameter int SEL_N = SEL_CYC,
	parameter int PUW_N = PUW_CYC,
	parameter int REC_N = RECOVERY_CYC,
	parameter int SRW_N = STATUS_WRITE_CYC,
	parameter int CYC_N = 1000
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Link from host
	fpsrc_if.device lnk,
	// Supply monitor
	input wire logic supply_ok,
	input wire logic supply_min_ok,
	// Observed state
	output logic [2:0] pwr_state,
	output logic write_latch_flag,
	output logic cycle_busy_flag,
	output logic [1:0] lock_bits,
	output logic reads_ready,
	output logic writes_ready,
	output logic [7:0] last_cmd,
	output logic cmd_exec
);
	// Input synchronisers
	logic [1:0] sel_s_ff, sck_s_ff, din_s_ff, rst_s_ff, sup_s_ff, min_s_ff;
	logic sel_d_ff, sck_d_ff;
	logic sel_n, sck, din, rpin_n, sup, supmin;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_s_ff <= 2'h3;
			sck_s_ff <= 2'h0;
			din_s_ff <= 2'h0;
			rst_s_ff <= 2'h3;
			sup_s_ff <= 2'h0;
			min_s_ff <= 2'h0;
		end else begin
			sel_s_ff <= {sel_s_ff[0], lnk.sel_n};
			sck_s_ff <= {sck_s_ff[0], lnk.sck};
			din_s_ff <= {din_s_ff[0], lnk.serial_in_line};
			rst_s_ff <= {rst_s_ff[0], lnk.hw_reset_n};
			sup_s_ff <= {sup_s_ff[0], supply_ok};
			min_s_ff <= {min_s_ff[0], supply_min_ok};
		end
	end
	assign sel_n = sel_s_ff[1];
	assign sck = sck_s_ff[1];
	assign din = din_s_ff[1];
	assign rpin_n = rst_s_ff[1];
	assign sup = sup_s_ff[1];
	assign supmin = min_s_ff[1];
	// Edge history
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_d_ff <= 1'b1;
			sck_d_ff <= 1'b0;
		end else begin
			sel_d_ff <= sel_n;
			sck_d_ff <= sck;
		end
	end
	logic sck_rise, sel_rise;
	assign sck_rise = !sel_n && sck && !sck_d_ff;
	assign sel_rise = sel_n && !sel_d_ff;
	// Logic reset: supply low only; reset pin handled per block
	logic lrst;
	assign lrst = !sup;
	// Power-up delay counters
	logic [31:0] puw_cnt_ff, sel_cnt_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || lrst) begin
			puw_cnt_ff <= '0;
		end else if (puw_cnt_ff < 32'(PUW_N)) begin
			puw_cnt_ff <= puw_cnt_ff + 32'h1;
		end
	end
	always_ff @(posedge aclk) begin
		if (!aresetn || lrst || !supmin) begin
			sel_cnt_ff <= '0;
		end else if (sel_cnt_ff < 32'(SEL_N)) begin
			sel_cnt_ff <= sel_cnt_ff + 32'h1;
		end
	end
	assign writes_ready = (puw_cnt_ff == 32'(PUW_N)) && (sel_cnt_ff == 32'(SEL_N));
	assign reads_ready = sel_cnt_ff == 32'(SEL_N);
	// Reset recovery counter, restarted by each pin low
	logic [31:0] rec_cnt_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || lrst || !rpin_n) begin
			rec_cnt_ff <= '0;
		end else if (rec_cnt_ff < 32'(REC_N)) begin
			rec_cnt_ff <= rec_cnt_ff + 32'h1;
		end
	end
	logic recovered;
	assign recovered = rec_cnt_ff == 32'(REC_N);
	// Command shifter, collects the first byte and counts clocks
	logic [7:0] sh_ff;
	logic [5:0] bits_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || lrst || sel_n) begin
			bits_ff <= '0;
			sh_ff <= '0;
		end else if (sck_rise) begin
			if (bits_ff < 6'd8) begin
				sh_ff <= {sh_ff[6:0], din};
			end
			if (bits_ff != 6'h3F) begin
				bits_ff <= bits_ff + 6'h1;
			end
		end
	end
	// Command ends on select rise; one byte exactly for DPD, RDP and WREN, not for WRDI
	logic done, onebyte, accept, srw_ff;
	assign done = sel_rise && bits_ff >= 6'd8 && recovered && sel_cnt_ff == 32'(SEL_N);
	assign onebyte = bits_ff == 6'd8;
	// Busy cycle timer
	logic [31:0] cyc_cnt_ff;
	fpsrc_pwr_e st_ff;
	logic is_wr;
	assign is_wr = sh_ff == CMD_WREN || sh_ff == CMD_PW || sh_ff == CMD_PP || sh_ff == CMD_PE || sh_ff == CMD_SE;
	// Command acceptance by state
	always_comb begin
		accept = 1'b0;
		if (done && st_ff == FPSRC_DEEP) begin
			accept = sh_ff == CMD_RDP && onebyte && !cycle_busy_flag;
		end else if (done && st_ff == FPSRC_STBY) begin
			if (cycle_busy_flag) begin
				accept = 1'b0;
			end else if (is_wr && !writes_ready) begin
				accept = 1'b0;
			end else begin
				accept = 1'b1;
			end
		end
	end
	// Power state machine
	logic [31:0] pc_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || lrst || !rpin_n) begin
			st_ff <= FPSRC_STBY;
			pc_ff <= '0;
		end else begin
			case (st_ff)
				FPSRC_STBY: begin
					if (accept && sh_ff == CMD_DPD && onebyte) begin
						st_ff <= FPSRC_ENTER;
						pc_ff <= '0;
					end
				end
				FPSRC_ENTER: begin
					pc_ff <= pc_ff + 32'h1;
					if (pc_ff + 32'h1 >= 32'(ENTRY_N)) begin
						st_ff <= FPSRC_DEEP;
					end
				end
				FPSRC_DEEP: begin
					if (accept) begin
						st_ff <= FPSRC_WAKE;
						pc_ff <= '0;
					end
				end
				FPSRC_WAKE: begin
					pc_ff <= pc_ff + 32'h1;
					if (pc_ff + 32'h1 >= 32'(WAKE_N)) begin
						st_ff <= FPSRC_STBY;
					end
				end
				default: begin
					st_ff <= FPSRC_STBY;
				end
			endcase
		end
	end
	assign pwr_state = st_ff;
	// Write latch, busy cycle and status write handling
	logic start_cyc;
	assign start_cyc = accept && st_ff == FPSRC_STBY && write_latch_flag &&
		(sh_ff == CMD_PW || sh_ff == CMD_PP || sh_ff == CMD_PE || sh_ff == CMD_SE || sh_ff == CMD_WRSR);
	always_ff @(posedge aclk) begin
		if (!aresetn || lrst) begin
			write_latch_flag <= 1'b0;
			cycle_busy_flag <= 1'b0;
			srw_ff <= 1'b0;
			cyc_cnt_ff <= '0;
		end else if (!rpin_n && !srw_ff) begin
			write_latch_flag <= 1'b0;
			cycle_busy_flag <= 1'b0;
			cyc_cnt_ff <= '0;
		end else if (cycle_busy_flag) begin
			cyc_cnt_ff <= cyc_cnt_ff + 32'h1;
			if (cyc_cnt_ff + 32'h1 >= (srw_ff ? 32'(SRW_N) : 32'(CYC_N))) begin
				cycle_busy_flag <= 1'b0;
				write_latch_flag <= 1'b0;
				srw_ff <= 1'b0;
			end
		end else if (start_cyc) begin
			cycle_busy_flag <= 1'b1;
			srw_ff <= sh_ff == CMD_WRSR;
			cyc_cnt_ff <= '0;
		end else if (accept && st_ff == FPSRC_STBY && sh_ff == CMD_WREN && onebyte) begin
			write_latch_flag <= 1'b1;
		end else if (accept && st_ff == FPSRC_STBY && sh_ff == CMD_WRDI) begin
			write_latch_flag <= 1'b0;
		end
	end
	// Lock bits cleared at power-up and by reset pin
	always_ff @(posedge aclk) begin
		if (!aresetn || lrst || !rpin_n) begin
			lock_bits <= 2'h0;
		end
	end
	// Last executed command
	always_ff @(posedge aclk) begin
		if (!aresetn || lrst) begin
			last_cmd <= 8'h00;
			cmd_exec <= 1'b0;
		end else begin
			cmd_exec <= accept;
			if (accept) begin
				last_cmd <= sh_ff;
			end
		end
	end
endmodule

// ==== core/fpsrc_host.sv ====
// Host end: AXI4-Lite command registers driving select, clock and data with delays
`timescale 1ns/100ps
module fpsrc_host import fpsrc_pkg::*; #(
	parameter int SEL_N = SEL_CYC,
	parameter int REC_N = RECOVERY_CYC,
	parameter int WAKE_N = WAKE_CYC
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [3:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	// AXI4-Lite read
	input wire logic [3:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// Link to device
	fpsrc_if.host lnk
);
	logic aw_ff, w_ff;
	logic [3:0] awa_ff;
	logic [31:0] wd_ff, ctrl_ff;
	logic [7:0] cmd_ff;
	logic [3:0] nbits_ff;
	logic busy_ff, done_ff;
	logic [31:0] dly_ff, sel_cnt_ff;
	logic [3:0] div_ff;
	logic sck_ff, sel_ff, dout_ff;
	// Write channel capture, either order
	assign s_awready = !aw_ff && !s_bvalid;
	assign s_wready = !w_ff && !s_bvalid;
	logic wr_go;
	assign wr_go = aw_ff && w_ff && !s_bvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awa_ff <= 4'h0;
			wd_ff <= 32'h0;
			s_bvalid <= 1'b0;
			s_bresp <= 2'h0;
		end else begin
			if (s_awvalid && s_awready) begin
				aw_ff <= 1'b1;
				awa_ff <= s_awaddr;
			end
			if (s_wvalid && s_wready) begin
				w_ff <= 1'b1;
				wd_ff <= s_wdata;
			end
			if (wr_go) begin
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
				s_bvalid <= 1'b1;
				s_bresp <= (awa_ff == REG_CMD || awa_ff == REG_CTRL) ? 2'h0 : 2'h2;
			end else if (s_bvalid && s_bready) begin
				s_bvalid <= 1'b0;
			end
		end
	end
	// Control register: bit0 holds reset pin low, bit1 extra clock
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_ff <= CTRL_RST;
		end else if (wr_go && awa_ff == REG_CTRL && s_wstrb[0]) begin
			ctrl_ff <= {30'h0, wd_ff[1:0]};
		end
	end
	// Select allowed only after supply-to-select delay since reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sel_cnt_ff <= '0;
		end else if (sel_cnt_ff < 32'(SEL_N)) begin
			sel_cnt_ff <= sel_cnt_ff + 32'h1;
		end
	end
	// Frame engine
	logic start;
	assign start = wr_go && awa_ff == REG_CMD && s_wstrb[0] && !busy_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			busy_ff <= 1'b0;
			done_ff <= 1'b0;
			cmd_ff <= 8'h00;
			nbits_ff <= 4'h0;
			div_ff <= 4'h0;
			sck_ff <= 1'b0;
			sel_ff <= 1'b1;
			dout_ff <= 1'b0;
			dly_ff <= '0;
		end else if (start) begin
			busy_ff <= 1'b1;
			done_ff <= 1'b0;
			cmd_ff <= wd_ff[7:0];
			nbits_ff <= ctrl_ff[1] ? 4'd9 : 4'd8;
			div_ff <= 4'h0;
			dly_ff <= '0;
		end else if (busy_ff) begin
			if (sel_ff) begin
				// Wait for power and reset delays, then select
				if (sel_cnt_ff == 32'(SEL_N) && !ctrl_ff[0] && dly_ff >= 32'(REC_N)) begin
					sel_ff <= 1'b0;
					dout_ff <= cmd_ff[7];
				end else begin
					dly_ff <= ctrl_ff[0] ? '0 : dly_ff + 32'h1;
				end
			end else if (nbits_ff != 4'h0) begin
				div_ff <= div_ff + 4'h1;
				if (div_ff == 4'(SCK_HALF - 1)) begin
					div_ff <= 4'h0;
					sck_ff <= !sck_ff;
					if (sck_ff) begin
						nbits_ff <= nbits_ff - 4'h1;
						cmd_ff <= {cmd_ff[6:0], 1'b0};
						dout_ff <= cmd_ff[6];
					end
				end
			end else begin
				sel_ff <= 1'b1;
				busy_ff <= 1'b0;
				done_ff <= 1'b1;
			end
		end
	end
	// Hold off after frame: report done only after wake delay
	logic [31:0] hold_ff;
	always_ff @(posedge aclk) begin
		if (!aresetn || start) begin
			hold_ff <= '0;
		end else if (done_ff && hold_ff < 32'(WAKE_N)) begin
			hold_ff <= hold_ff + 32'h1;
		end
	end
	assign lnk.sel_n = sel_ff;
	assign lnk.sck = sck_ff;
	assign lnk.serial_in_line = dout_ff;
	assign lnk.hw_reset_n = !ctrl_ff[0];
	// Read channel
	assign s_arready = !s_rvalid;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_rvalid <= 1'b0;
			s_rdata <= 32'h0;
			s_rresp <= 2'h0;
		end else if (s_arvalid && s_arready) begin
			s_rvalid <= 1'b1;
			s_rresp <= 2'h0;
			if (s_araddr == REG_STAT) begin
				s_rdata <= {28'h0, dly_ff >= 32'(REC_N), sel_cnt_ff == 32'(SEL_N),
					done_ff && hold_ff == 32'(WAKE_N), busy_ff};
			end else if (s_araddr == REG_CTRL) begin
				s_rdata <= ctrl_ff;
			end else if (s_araddr == REG_CMD) begin
				s_rdata <= {24'h0, cmd_ff};
			end else begin
				s_rdata <= 32'h0;
				s_rresp <= 2'h2;
			end
		end else if (s_rvalid && s_rready) begin
			s_rvalid <= 1'b0;
		end
	end
endmodule

// ==== sim/fpsrc_monitor.sv ====
// Checker on the link wires and the device power state
`timescale 1ns/100ps
module fpsrc_monitor import fpsrc_pkg::*; #(
	parameter int WAKE_N = 10,
	parameter int ENTRY_N = 10
) (
	// Clock, reset and link
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic sel_n,
	input wire logic sck,
	input wire logic hw_reset_n,
	// Supply and device state
	input wire logic supply_ok,
	input wire logic [2:0] pwr_state,
	input wire logic write_latch_flag,
	input wire logic cycle_busy_flag,
	input wire logic [1:0] lock_bits,
	input wire logic [7:0] last_cmd,
	input wire logic cmd_exec,
	input wire logic writes_ready
);
	localparam int WAKE_HI = WAKE_N + 4;
	localparam int ENTRY_HI = ENTRY_N + 4;
	// One domain for all checks
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sck_framed_a: assert property ($rose(sck) |-> !sel_n)
		else $error("serial clock rose while deselected");
	wake_hold_a: assert property ($rose(pwr_state == FPSRC_WAKE) |->
		(pwr_state == FPSRC_WAKE)[*8] ##[1:WAKE_HI] pwr_state == FPSRC_STBY) else $error("wake delay wrong");
	entry_hold_a: assert property ($rose(pwr_state == FPSRC_ENTER) |->
		(pwr_state == FPSRC_ENTER)[*8] ##[1:ENTRY_HI] pwr_state == FPSRC_DEEP) else $error("entry delay wrong");
	supply_quiet_a: assert property (!supply_ok[*4] |->
		!cmd_exec && !write_latch_flag && !cycle_busy_flag) else $error("active with supply low");
	powerup_clean_a: assert property ($rose(supply_ok) |-> pwr_state == FPSRC_STBY &&
		!write_latch_flag && !cycle_busy_flag && lock_bits == 2'b00) else $error("power-up state wrong");
	early_write_a: assert property (!writes_ready |-> !write_latch_flag)
		else $error("write latch set before write delay");
	reset_abort_a: assert property ($fell(hw_reset_n) && cycle_busy_flag && last_cmd != CMD_WRSR |->
		##[1:5] !cycle_busy_flag && lock_bits == 2'b00) else $error("reset pin did not abort cycle");
	status_finish_a: assert property ($fell(hw_reset_n) && cycle_busy_flag && last_cmd == CMD_WRSR |->
		cycle_busy_flag[*6]) else $error("status write cut short");
	recovery_gap_a: assert property ($rose(hw_reset_n) |-> sel_n[*8])
		else $error("select too soon after reset pin");
	// Main scenarios reached
	cover property ($rose(pwr_state == FPSRC_DEEP));
	cover property ($rose(pwr_state == FPSRC_WAKE));
	cover property ($fell(hw_reset_n) && cycle_busy_flag);
endmodule

// ==== sim/tb.sv ====
// Testbench joining host and device ends over the link
`timescale 1ns/100ps
module tb import fpsrc_pkg::*;;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic supply_ok = 1'b0;
	logic supply_min_ok = 1'b0;
	logic [3:0] s_awaddr = 4'h0;
	logic [3:0] s_araddr = 4'h0;
	logic [31:0] s_wdata = 32'h0;
	logic [3:0] s_wstrb = 4'h0;
	// Shortened delays so every scenario fits the run
	localparam int H_SEL = 30;
	localparam int H_REC = 16;
	localparam int H_WAKE = 16;
	localparam int D_WAKE = 10;
	localparam int D_ENTRY = 10;
	localparam int D_SEL = 20;
	localparam int D_PUW = 400;
	localparam int D_REC = 10;
	localparam int D_SRW = 200;
	localparam int D_CYC = 300;
	logic s_awvalid = 1'b0;
	logic s_wvalid = 1'b0;
	logic s_bready = 1'b0;
	logic s_arvalid = 1'b0;
	logic s_rready = 1'b0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp, lock_bits, rsp;
	logic [31:0] s_rdata, rd;
	logic [2:0] pwr_state;
	logic write_latch_flag, cycle_busy_flag, reads_ready, writes_ready, cmd_exec;
	logic [7:0] last_cmd;
	int miscompares = 0;
	int n_compared = 0;
	logic sck_q = 1'b0;
	logic sel_q = 1'b1;
	int bit_cnt = 0;
	int frame_bits = 0;
	logic [7:0] shreg = 8'h00;
	logic [7:0] frame_byte = 8'h00;

	// Clock
	always #2.5 aclk = ~aclk;

	fpsrc_if lnk_if();
	fpsrc_host #(.SEL_N(H_SEL), .REC_N(H_REC), .WAKE_N(H_WAKE)) fpsrc_host_inst (.aclk(aclk), .aresetn(aresetn),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
		.s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready), .s_rdata(s_rdata),
		.s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready), .lnk(lnk_if.host));
	fpsrc_device #(.WAKE_N(D_WAKE), .ENTRY_N(D_ENTRY), .SEL_N(D_SEL), .PUW_N(D_PUW), .REC_N(D_REC),
		.SRW_N(D_SRW), .CYC_N(D_CYC))
		fpsrc_device_inst (.aclk(aclk), .aresetn(aresetn), .lnk(lnk_if.device), .supply_ok(supply_ok),
		.supply_min_ok(supply_min_ok), .pwr_state(pwr_state), .write_latch_flag(write_latch_flag),
		.cycle_busy_flag(cycle_busy_flag), .lock_bits(lock_bits), .reads_ready(reads_ready),
		.writes_ready(writes_ready), .last_cmd(last_cmd), .cmd_exec(cmd_exec));
	fpsrc_monitor #(.WAKE_N(D_WAKE), .ENTRY_N(D_ENTRY)) fpsrc_monitor_inst (.aclk(aclk), .aresetn(aresetn),
		.sel_n(lnk_if.sel_n), .sck(lnk_if.sck), .hw_reset_n(lnk_if.hw_reset_n), .supply_ok(supply_ok),
		.pwr_state(pwr_state), .write_latch_flag(write_latch_flag), .cycle_busy_flag(cycle_busy_flag),
		.lock_bits(lock_bits), .last_cmd(last_cmd), .cmd_exec(cmd_exec), .writes_ready(writes_ready));

	// Capture bits on the wire, first eight MSB first
	always @(posedge aclk) begin
		sck_q <= lnk_if.sck;
		sel_q <= lnk_if.sel_n;
		if (!lnk_if.sel_n && lnk_if.sck && !sck_q) begin
			bit_cnt <= bit_cnt + 1;
			if (bit_cnt < 8) shreg <= {shreg[6:0], lnk_if.serial_in_line};
		end
		if (lnk_if.sel_n && !sel_q) begin
			frame_bits <= bit_cnt;
			frame_byte <= shreg;
			bit_cnt <= 0;
		end
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic results();
		$display("Compared %0d, mismatches %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic stop_wait();
		chk("wait bound", 32'h0, 32'h1);
		results();
	endtask

	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge aclk);
		s_awaddr <= a;
		s_wdata <= d;
		s_wstrb <= 4'hF;
		s_awvalid <= 1'b1;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_awready) s_awvalid <= 1'b0;
			if (s_wready) s_wvalid <= 1'b0;
		end while (!s_bvalid && n < 200);
		rsp = s_bresp;
		s_bready <= 1'b0;
		if (n >= 200) stop_wait();
	endtask

	task automatic axi_rd(input logic [3:0] a);
		int n;
		n = 0;
		@(posedge aclk);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_arready) s_arvalid <= 1'b0;
		end while (!s_rvalid && n < 200);
		rd = s_rdata;
		rsp = s_rresp;
		s_rready <= 1'b0;
		if (n >= 200) stop_wait();
	endtask

	task automatic poll_stat(input int b);
		int n;
		n = 0;
		do begin
			axi_rd(REG_STAT);
			n++;
		end while (!(rd[b] === 1'b1 && rd[ST_BUSY] === 1'b0) && n < 300);
		if (n >= 300) stop_wait();
	endtask

	task automatic wait_bit(ref logic s, input logic v);
		int n;
		n = 0;
		while (s !== v && n < 2000) begin
			@(posedge aclk);
			n++;
		end
		if (n >= 2000) stop_wait();
	endtask

	task automatic send(input logic [7:0] b, input int nbits);
		axi_wr(REG_CMD, {24'h000000, b});
		poll_stat(ST_DONE);
		repeat (6) @(posedge aclk);
		chk("frame bits", frame_bits, nbits);
		chk("frame byte", frame_byte, b);
	endtask

	// Main sequence
	initial begin
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		chk("reset state", pwr_state, FPSRC_STBY);
		chk("delivered flags", {write_latch_flag, cycle_busy_flag, lock_bits}, 4'h0);
		@(posedge aclk);
		supply_ok <= 1'b1;
		supply_min_ok <= 1'b1;
		axi_rd(4'hC);
		chk("unmapped resp", rsp, 32'h2);
		chk("unmapped data", rd, 32'h0);
		poll_stat(ST_PWRUP);
		send(CMD_READ, 8);
		chk("read early", {last_cmd, reads_ready, writes_ready}, {CMD_READ, 2'b10});
		send(CMD_WREN, 8);
		chk("early wren", write_latch_flag, 1'b0);
		wait_bit(writes_ready, 1'b1);
		send(CMD_WREN, 8);
		chk("wren", write_latch_flag, 1'b1);
		send(CMD_WRDI, 8);
		chk("wrdi", write_latch_flag, 1'b0);
		send(CMD_WREN, 8);
		send(CMD_PP, 8);
		send(CMD_RDP, 8);
		chk("release in busy", {cycle_busy_flag, pwr_state}, {1'b1, FPSRC_STBY});
		wait_bit(cycle_busy_flag, 1'b0);
		send(CMD_DPD, 8);
		repeat (20) @(posedge aclk);
		send(CMD_WREN, 8);
		chk("deep ignores", {write_latch_flag, pwr_state}, {1'b0, FPSRC_DEEP});
		axi_wr(REG_CTRL, 32'h0000_0002);
		send(CMD_RDP, 9);
		chk("long release", pwr_state, FPSRC_DEEP);
		axi_wr(REG_CTRL, CTRL_RST);
		send(CMD_RDP, 8);
		chk("woken", pwr_state, FPSRC_STBY);
		// Reset pin during a program cycle
		send(CMD_WREN, 8);
		send(CMD_PP, 8);
		axi_wr(REG_CTRL, 32'h0000_0001);
		wait_bit(cycle_busy_flag, 1'b0);
		chk("abort", {pwr_state, lock_bits}, {FPSRC_STBY, 2'b00});
		axi_wr(REG_CTRL, CTRL_RST);
		poll_stat(ST_REC);
		// Reset pin during a status write
		wait_bit(writes_ready, 1'b1);
		send(CMD_WREN, 8);
		send(CMD_WRSR, 8);
		axi_wr(REG_CTRL, 32'h0000_0001);
		chk("status write runs", cycle_busy_flag, 1'b1);
		wait_bit(cycle_busy_flag, 1'b0);
		chk("after status write", {write_latch_flag, lock_bits}, 3'h0);
		axi_wr(REG_CTRL, CTRL_RST);
		poll_stat(ST_REC);
		chk("idle reset", {pwr_state, lock_bits}, {FPSRC_STBY, 2'b00});
		// Supply below threshold
		wait_bit(writes_ready, 1'b1);
		supply_ok <= 1'b0;
		send(CMD_WREN, 8);
		chk("supply low", {write_latch_flag, cycle_busy_flag}, 2'b00);
		supply_ok <= 1'b1;
		repeat (4) @(posedge aclk);
		results();
	end
endmodule
